// ===== hdl/common_control_status_regs.sv
// Shared control, command and status register group of a three-channel front end.
// Assumes a serial front end on clk issuing one-cycle read and write strobes.
// Operation
// - Config bit 15 picks latching or transparent window comparator output.
// - Lock bit blocks writes; unlock needs password 0101, then lock written 0.
// - Fetch bit reads one dump row chosen by bit 13, then self-clears.
// - Channel 1 and 0 sleep fields: up, 10k, 100k, high-Z; reset 3.
// - Channel 2 sleep field 00 powers up; others pull down 1.2k.
// - Reset field written 1010 fires full reset and self-clears.
// - Sync load bit updates sync-configured channels, then self-clears.
// - Zeroing bit forces data to zero or mid code, then self-clears.
// - Dump bit launches fault dump and self-clears; zero does nothing.
// - Protect bit starts protective shutdown and self-clears.
// - Protect flag reads 1 while active or done; clears on read.
// - Bit 1 programs memory, bit 0 reloads map; both self-clear.
// - Margin low and high bits launch margin commands, then self-clear.
// - Waveform bits start generation when 1, stop when 0.
// - Hold-clear bit clears the latched window result output, then self-clears.
// - Factory and user load error flags, cleared by software reset.
// - Conversion-valid flag resets 1, drops on trigger, rises when valid.
// - Busy flags read 1 while a channel rejects commands.
// - Memory busy flag reads 1 while memory cannot accept work.
// - Window result bit latched or transparent per hold select.
// - Comparator bit is synchronised raw output, reset 1.
// - While locked, password writes and two-wire reset-field writes still land.
`timescale 1ns/100ps
`include "ccs_defs.svh"
module common_control_status_regs #(
  parameter logic [5:0] PART_ID = 6'h2a, // Arbitrary value.
  parameter logic [1:0] REV_ID  = 2'h3   // Arbitrary value.
) (
  input  wire logic               clk,          // 10 MHz clock.
  input  wire logic               rst_n,        // Synchronous reset, low.
  input  wire ccs_pkg::reg_req_s  req,          // Register access request.
  output logic [15:0]             rdata,        // Read data, registered.
  input  wire ccs_pkg::status_in_s stat,        // Status from device, same clock.
  input  wire logic               win_cmp_raw,  // Window comparator pin level.
  input  wire logic               cmp_raw,      // Comparator pin level.
  output ccs_pkg::launch_s        launch,       // One-cycle action launches.
  output logic                    dump_row,     // Row address of a fetch.
  output logic                    int_ref_en,   // Internal reference enable.
  output logic [1:0]              ch0_sleep_load, // Channel 0 power-down load.
  output logic [1:0]              ch1_sleep_load, // Channel 1 power-down load.
  output logic [1:0]              ch2_sleep_load, // Channel 2 power-down load.
  output logic                    window_hold_select, // Latching window output.
  output logic                    map_write_guard,    // Map locked.
  output logic [2:0]              waveform_run,   // Waveform run 0,1,2.
  output logic                    ch1_window_result   // Reported window result.
);
  import ccs_pkg::*;

  // ===================================================================
  // State
  logic [15:0] cfg_q, cfg_d;
  logic [3:0]  pass_q, pass_d;
  logic [2:0]  wave_q, wave_d;
  launch_s     launch_q, launch_d;
  logic        factory_q, factory_d, user_q, user_d;
  logic        conv_q, conv_d, prot_q, prot_d;
  logic        win_q, win_d, cmp_q, cmp_d;
  logic [1:0]  win_sync_q, cmp_sync_q;
  logic [15:0] rdata_q, rdata_d;
  logic        wr_cfg, wr_cmd, wr_act, rd_cmp, locked, win_s, cmp_s;

  // Two-stage synchronisers for the comparator pins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_sync_q <= 2'h0;
      cmp_sync_q <= 2'h3;
    end else begin
      win_sync_q <= {win_sync_q[0], win_cmp_raw};
      cmp_sync_q <= {cmp_sync_q[0], cmp_raw};
    end
  end
  assign win_s = win_sync_q[1];
  assign cmp_s = cmp_sync_q[1];

  // Address decode and write gating by the map lock.
  assign locked = cfg_q[`CFG_GUARD_BIT];
  assign wr_cfg = req.wr && (req.addr == `OFS_SHARED_CONFIG);
  assign wr_cmd = req.wr && (req.addr == `OFS_GLOBAL_CMD);
  assign wr_act = req.wr && (req.addr == `OFS_CHANNEL_ACTION) && !locked;
  assign rd_cmp = req.rd && (req.addr == `OFS_COMPARATOR);

  // ===================================================================
  // Configuration, password, waveform run and command launches.
  always_comb begin
    cfg_d    = cfg_q;
    pass_d   = pass_q;
    wave_d   = wave_q;
    launch_d = '0; // Every launch lasts one cycle.
    if (wr_cfg) begin
      if (!locked) begin
        cfg_d = req.wdata;
      end else if (pass_q == `GUARD_PASSWORD && !req.wdata[`CFG_GUARD_BIT]) begin
        cfg_d[`CFG_GUARD_BIT] = 1'b0; // Unlock only after password.
        pass_d = 4'h0;
      end
    end
    if (wr_cmd) begin
      pass_d = req.wdata[`CMD_PASS_HI:`CMD_PASS_LO]; // Accepted when locked.
      if (req.wdata[`CMD_RESET_HI:`CMD_RESET_LO] == `RESET_KEY
          && (!locked || req.via_i2c)) begin
        launch_d.por = 1'b1;
      end
      if (!locked) begin
        launch_d.sync_load = req.wdata[`CMD_SYNC_BIT];
        launch_d.zeroing   = req.wdata[`CMD_ZERO_BIT];
        launch_d.dump      = req.wdata[`CMD_DUMP_BIT];
        launch_d.protect   = req.wdata[`CMD_PROT_BIT];
        launch_d.fetch     = req.wdata[`CMD_FETCH_BIT];
        launch_d.persist   = req.wdata[`CMD_PERSIST_BIT];
        launch_d.restore   = req.wdata[`CMD_RESTORE_BIT];
      end
    end
    if (wr_act) begin
      launch_d.low_limit  = {req.wdata[14], req.wdata[2], req.wdata[6]};
      launch_d.high_limit = {req.wdata[13], req.wdata[1], req.wdata[5]};
      wave_d = {req.wdata[12], req.wdata[0], req.wdata[4]};
    end
    if (launch_q.por) begin
      cfg_d  = `RST_SHARED_CONFIG;
      pass_d = 4'h0;
      wave_d = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q    <= `RST_SHARED_CONFIG;
      pass_q   <= 4'h0;
      wave_q   <= 3'h0;
      launch_q <= '0;
    end else begin
      cfg_q    <= cfg_d;
      pass_q   <= pass_d;
      wave_q   <= wave_d;
      launch_q <= launch_d;
    end
  end

  // ===================================================================
  // Status flags; a setting event wins over a clear in the same cycle, except conversion-valid and window result, where the clear wins.
  always_comb begin
    factory_d = factory_q | stat.factory_load_error;
    user_d    = user_q | stat.user_load_error;
    if (launch_q.por) begin
      factory_d = stat.factory_load_error;
      user_d    = stat.user_load_error;
    end
    conv_d = conv_q;
    if (stat.conv_start) begin
      conv_d = 1'b0;
    end else if (stat.conv_done) begin
      conv_d = 1'b1;
    end
    prot_d = (rd_cmp ? 1'b0 : prot_q) | stat.protect_active | launch_q.protect;
    if (!cfg_q[`CFG_HOLD_BIT]) begin
      win_d = win_s; // Transparent.
    end else begin
      win_d = win_q | win_s; // Held until cleared.
    end
    if (wr_act && req.wdata[`ACT_HOLD_CLEAR_BIT]) begin
      win_d = 1'b0;
    end
    cmp_d = cmp_s;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      factory_q <= 1'b0;
      user_q    <= 1'b0;
      conv_q    <= 1'b1;
      prot_q    <= 1'b0;
      win_q     <= 1'b0;
      cmp_q     <= 1'b1;
    end else begin
      factory_q <= factory_d;
      user_q    <= user_d;
      conv_q    <= conv_d;
      prot_q    <= prot_d;
      win_q     <= win_d;
      cmp_q     <= cmp_d;
    end
  end

  // ===================================================================
  // Read data; command bits always read back 0 since they self-clear.
  always_comb begin
    rdata_d = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        `OFS_SHARED_CONFIG: rdata_d = cfg_q;
        `OFS_GLOBAL_CMD: rdata_d = {pass_q, 12'h000};
        `OFS_CHANNEL_ACTION: rdata_d = {3'h0, wave_q[2], 7'h00, wave_q[0], 3'h0, wave_q[1]};
        `OFS_CONDITION_FLAGS: rdata_d = {factory_q, user_q, conv_q, stat.busy[1],
                                         stat.busy[0], 1'b0, stat.busy[2],
                                         stat.persist_occupied, PART_ID, REV_ID};
        `OFS_COMPARATOR: rdata_d = {7'h00, prot_q, win_q, 3'h0, cmp_q, 3'h4};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Output mapping.
  assign rdata              = rdata_q;
  assign launch             = launch_q;
  assign dump_row           = cfg_q[`CFG_ROW_BIT];
  assign int_ref_en         = cfg_q[`CFG_REF_BIT];
  assign ch1_sleep_load     = cfg_q[`CFG_CH1_SLEEP_HI:`CFG_CH1_SLEEP_LO];
  assign ch0_sleep_load     = cfg_q[`CFG_CH0_SLEEP_HI:`CFG_CH0_SLEEP_LO];
  assign ch2_sleep_load     = cfg_q[`CFG_CH2_SLEEP_HI:`CFG_CH2_SLEEP_LO];
  assign window_hold_select = cfg_q[`CFG_HOLD_BIT];
  assign map_write_guard    = locked;
  assign waveform_run       = wave_q;
  assign ch1_window_result  = win_q;
endmodule : common_control_status_regs

// ===== inc/ccs_defs.svh
// Offsets, field positions, reset values and codes of the shared control group.
// Assumes inclusion by the register-bank module only; the package does not include it.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
// =====================================================================
// Register offsets
`define OFS_SHARED_CONFIG   8'h1f
`define OFS_GLOBAL_CMD      8'h20
`define OFS_CHANNEL_ACTION  8'h21
`define OFS_CONDITION_FLAGS 8'h22
`define OFS_COMPARATOR      8'h23
// =====================================================================
// Reset values
`define RST_SHARED_CONFIG   16'h0fff
`define RST_COMPARATOR      16'h000c
// =====================================================================
// Shared configuration fields
`define CFG_HOLD_BIT        15
`define CFG_GUARD_BIT       14
`define CFG_ROW_BIT         13
`define CFG_REF_BIT         12
`define CFG_CH1_SLEEP_HI    11
`define CFG_CH1_SLEEP_LO    10
`define CFG_CH0_SLEEP_HI    8
`define CFG_CH0_SLEEP_LO    7
`define CFG_CH2_SLEEP_HI    2
`define CFG_CH2_SLEEP_LO    1
// =====================================================================
// Global command fields
`define CMD_PASS_HI         15
`define CMD_PASS_LO         12
`define CMD_RESET_HI        11
`define CMD_RESET_LO        8
`define CMD_SYNC_BIT        7
`define CMD_ZERO_BIT        6
`define CMD_DUMP_BIT        4
`define CMD_PROT_BIT        3
`define CMD_FETCH_BIT       2
`define CMD_PERSIST_BIT     1
`define CMD_RESTORE_BIT     0
`define GUARD_PASSWORD      4'h5
`define RESET_KEY           4'ha
// =====================================================================
// Channel action fields (channel order 0,1,2)
`define ACT_HOLD_CLEAR_BIT  3
`define ACT_WAVE_MASK       16'h1011
// =====================================================================
// Status field positions
`define ST_FACTORY_BIT      15
`define ST_USER_BIT         14
`define ST_CONV_BIT         13
`define ST_CH1_BUSY_BIT     12
`define ST_CH0_BUSY_BIT     11
`define ST_CH2_BUSY_BIT     9
`define ST_PERSIST_BIT      8
`define CMP_PROT_BIT        8
`define CMP_WIN_BIT         7
`define CMP_RAW_BIT         3
`endif

// ===== inc/ccs_pkg.sv
// Types shared by the control group and its surroundings.
// Assumes the defs header sits beside it on the include path.
package ccs_pkg;
  // ===================================================================
  // Register access request from the serial front end.
  typedef struct packed {
    logic        wr;      // One-cycle write strobe.
    logic        rd;      // One-cycle read strobe.
    logic        via_i2c; // Access arrived over the two-wire port.
    logic [7:0]  addr;    // Register offset.
    logic [15:0] wdata;   // Write data.
  } reg_req_s;

  // One-cycle action launches toward the channels and memory.
  typedef struct packed {
    logic       por;       // Full power-on-style reset.
    logic       sync_load; // Load every sync-configured channel.
    logic       zeroing;   // Force data to zero or mid code.
    logic       dump;      // Fault-dump sequence into memory.
    logic       protect;   // Protective shutdown.
    logic       fetch;     // Read one dump row.
    logic       persist;   // Program register settings.
    logic       restore;   // Reload register map.
    logic [2:0] low_limit; // Margin-low per channel 0,1,2.
    logic [2:0] high_limit;// Margin-high per channel 0,1,2.
  } launch_s;

  // Status levels reported by the surrounding device.
  typedef struct packed {
    logic       factory_load_error; // Factory load check failed.
    logic       user_load_error;    // User load check failed.
    logic       conv_start;         // Conversion triggered, one cycle.
    logic       conv_done;          // Conversion result valid, one cycle.
    logic [2:0] busy;               // Channel busy 0,1,2.
    logic       persist_occupied;   // Memory unable to accept work.
    logic       protect_active;     // Protect in progress.
  } status_in_s;
endpackage : ccs_pkg

// ===== verif/ccs_regs_sva.sv
// Assertion checker for the shared control and status register group.
// Assumes it is bound onto the register group top module, one clock domain.
`timescale 1ns/100ps
module ccs_regs_sva (
  input wire logic                clk,                // Clock.
  input wire logic                rst_n,              // Synchronous reset, low.
  input wire ccs_pkg::reg_req_s   req,                // Access request.
  input wire ccs_pkg::launch_s    launch,             // Action pulses.
  input wire logic                map_write_guard,    // Map locked.
  input wire logic                window_hold_select, // Latching window.
  input wire logic                int_ref_en,         // Reference enable.
  input wire logic [1:0]          ch0_sleep_load,     // Channel 0 load.
  input wire logic [1:0]          ch1_sleep_load,     // Channel 1 load.
  input wire logic [2:0]          waveform_run        // Waveform run.
);
  import ccs_pkg::*;
  // =====================================================================
  // Helper decodes of the request and of the configuration outputs.
  logic w1f, w20, w21, key;
  logic [5:0] cfg_v, wcfg;
  logic [2:0] wwav, wlo, whi;
  assign w1f   = req.wr && req.addr == 8'h1f;
  assign w20   = req.wr && req.addr == 8'h20;
  assign w21   = req.wr && req.addr == 8'h21;
  assign key   = w20 && req.wdata[11:8] == 4'ha;
  assign cfg_v = {window_hold_select, int_ref_en, ch1_sleep_load, ch0_sleep_load};
  assign wcfg  = {req.wdata[15], req.wdata[12], req.wdata[11:10], req.wdata[8:7]};
  assign wwav  = {req.wdata[12], req.wdata[0], req.wdata[4]};
  assign wlo   = {req.wdata[14], req.wdata[2], req.wdata[6]};
  assign whi   = {req.wdata[13], req.wdata[1], req.wdata[5]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // Properties.
  property p_sync; w20 && req.wdata[7] && !map_write_guard |=> launch.sync_load; endproperty
  a_sync: assert property (p_sync) else $error("sync load missed");
  property p_por; key && (!map_write_guard || req.via_i2c) |=> launch.por; endproperty
  a_por: assert property (p_por) else $error("reset key missed");
  property p_por_key; launch.por |-> $past(key); endproperty
  a_por_key: assert property (p_por_key) else $error("reset without key");
  property p_clear; launch.dump && !req.wr |=> !launch.dump; endproperty
  a_clear: assert property (p_clear) else $error("dump pulse stuck");
  property p_cfg; w1f && !map_write_guard && !launch.por |=> cfg_v == $past(wcfg); endproperty
  a_cfg: assert property (p_cfg) else $error("config write lost");
  property p_guard; map_write_guard && !launch.por && !key |=> $stable(cfg_v); endproperty
  a_guard: assert property (p_guard) else $error("locked config changed");
  property p_wave; w21 && !map_write_guard && !launch.por |=> waveform_run == $past(wwav);
  endproperty
  a_wave: assert property (p_wave) else $error("waveform run wrong");
  property p_margin; w21 && !map_write_guard |=>
    launch.low_limit == $past(wlo) && launch.high_limit == $past(whi); endproperty
  a_margin: assert property (p_margin) else $error("margin pulse wrong");
endmodule : ccs_regs_sva
bind common_control_status_regs ccs_regs_sva u_sva (.clk(clk), .rst_n(rst_n), .req(req),
  .launch(launch), .map_write_guard(map_write_guard), .window_hold_select(window_hold_select),
  .int_ref_en(int_ref_en), .ch0_sleep_load(ch0_sleep_load), .ch1_sleep_load(ch1_sleep_load),
  .waveform_run(waveform_run));

// ===== verif/ccs_host_model.sv
// Host controller model issuing register accesses to the control group.
// Assumes requests are launched on the falling clock edge, one at a time.
`timescale 1ns/100ps
module ccs_host_model (
  input wire logic         clk,   // Clock.
  output ccs_pkg::reg_req_s req,  // Access request.
  input wire logic [15:0]  rdata  // Read data.
);
  import ccs_pkg::*;
  // Idle request at start.
  initial req = '{wr: 1'b0, rd: 1'b0, via_i2c: 1'b0, addr: 8'h00, wdata: 16'h0000};
  // One write strobe; data is inverted after release so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic i = 1'b0);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, via_i2c: i, addr: a, wdata: d};
    @(negedge clk);
    req.wr    <= 1'b0;
    req.wdata <= ~d;
  endtask : wr
  // One read strobe; data is taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(negedge clk);
    req.rd <= 1'b0;
    d = rdata;
  endtask : rd
  // Password first, then the lock bit written as zero.
  task automatic unlock(input logic [15:0] cfg);
    wr(8'h20, 16'h5000);
    wr(8'h1f, cfg);
  endtask : unlock
endmodule : ccs_host_model

// ===== verif/common_control_status_regs_tb_top.sv
// Self-checking bench for the shared control and status register group.
// Assumes the host model and the bound checker are compiled beside it.
`timescale 1ns/100ps
module common_control_status_regs_tb_top;
  import ccs_pkg::*;
  logic       clk, rst_n, win_cmp_raw, cmp_raw, dump_row, int_ref_en;
  logic       window_hold_select, map_write_guard, ch1_window_result;
  logic [1:0] ch0_sleep_load, ch1_sleep_load, ch2_sleep_load;
  logic [2:0] waveform_run;
  logic [15:0] rdata, d, v;
  logic [7:0] acts;
  reg_req_s   req;
  status_in_s stat;
  launch_s    launch;
  int         miscompares, n_tests;
  assign acts = {launch.por, launch.sync_load, launch.zeroing, launch.dump,
                 launch.protect, launch.fetch, launch.persist, launch.restore};
  common_control_status_regs u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .stat(stat), .win_cmp_raw(win_cmp_raw), .cmp_raw(cmp_raw), .launch(launch),
    .dump_row(dump_row), .int_ref_en(int_ref_en), .ch0_sleep_load(ch0_sleep_load),
    .ch1_sleep_load(ch1_sleep_load), .ch2_sleep_load(ch2_sleep_load),
    .window_hold_select(window_hold_select), .map_write_guard(map_write_guard),
    .waveform_run(waveform_run), .ch1_window_result(ch1_window_result));
  ccs_host_model u_host (.clk(clk), .req(req), .rdata(rdata));
  // =====================================================================
  // Compare, register check and closing tasks.
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    u_host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask : rc
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog well beyond the fewer than 150 cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  // =====================================================================
  // Test sequence.
  initial begin
    stat = '0; win_cmp_raw = 1'b0; cmp_raw = 1'b1; rst_n = 1'b0;
    miscompares = 0; n_tests = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rc(8'h1f, 16'h0fff);
    rc(8'h22, 16'h20ab);
    rc(8'h23, 16'h000c);
    rc(8'h30, 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      v = 16'h3279 | 16'(k << 10) | 16'(k << 7) | 16'(k << 1);
      u_host.wr(8'h1f, v);
      chk("ch0 load", ch0_sleep_load, 16'(k));
      chk("ch1 load", ch1_sleep_load, 16'(k));
      chk("ch2 load", ch2_sleep_load, 16'(k));
      chk("reference", int_ref_en, 16'h1);
      rc(8'h1f, v);
    end
    $display("test config done");
    for (int b = 0; b < 8; b++) if (b != 5) begin
      u_host.wr(8'h20, 16'(1 << b));
      chk("command", acts, 16'(1 << (b > 4 ? b - 1 : b)));
      chk("dump row", dump_row, 16'h1);
      @(negedge clk);
      chk("self clear", acts, 16'h0);
    end
    rc(8'h20, 16'h0000);
    u_host.wr(8'h20, 16'h0008);
    rc(8'h23, 16'h010c);
    rc(8'h23, 16'h000c);
    u_host.wr(8'h20, 16'h0500);
    chk("wrong key", acts, 16'h0);
    u_host.wr(8'h20, 16'h0a00);
    chk("reset key", acts, 16'h80);
    @(negedge clk);
    rc(8'h1f, 16'h0fff);
    $display("test commands done");
    u_host.wr(8'h21, 16'h4021);
    chk("low", launch.low_limit, 16'h4);
    chk("high", launch.high_limit, 16'h1);
    chk("wave", waveform_run, 16'h2);
    rc(8'h21, 16'h0001);
    u_host.wr(8'h21, 16'h7077);
    chk("low all", launch.low_limit, 16'h7);
    chk("wave all", waveform_run, 16'h7);
    u_host.wr(8'h21, 16'h0000);
    chk("wave stop", waveform_run, 16'h0);
    $display("test channel done");
    stat = '{1'b1, 1'b1, 1'b0, 1'b0, 3'b111, 1'b1, 1'b0};
    rc(8'h22, 16'hfbab);
    stat = '0;
    stat.conv_start = 1'b1;
    @(negedge clk);
    stat.conv_start = 1'b0;
    rc(8'h22, 16'hc0ab);
    stat.conv_done = 1'b1;
    @(negedge clk);
    stat.conv_done = 1'b0;
    rc(8'h22, 16'he0ab);
    $display("test status done");
    cmp_raw = 1'b0;
    repeat (4) @(negedge clk);
    rc(8'h23, 16'h0004);
    u_host.wr(8'h1f, 16'h8fff);
    win_cmp_raw = 1'b1;
    repeat (4) @(negedge clk);
    win_cmp_raw = 1'b0;
    repeat (4) @(negedge clk);
    chk("latched", ch1_window_result, 16'h1);
    rc(8'h23, 16'h0084);
    u_host.wr(8'h21, 16'h0008);
    @(negedge clk);
    chk("hold clear", ch1_window_result, 16'h0);
    u_host.wr(8'h1f, 16'h0fff);
    win_cmp_raw = 1'b1;
    repeat (4) @(negedge clk);
    chk("follow high", ch1_window_result, 16'h1);
    win_cmp_raw = 1'b0;
    repeat (4) @(negedge clk);
    chk("follow low", ch1_window_result, 16'h0);
    $display("test compare done");
    u_host.wr(8'h1f, 16'h4fff);
    chk("locked", map_write_guard, 16'h1);
    u_host.wr(8'h1f, 16'h0000);
    rc(8'h1f, 16'h4fff);
    u_host.wr(8'h20, 16'h0080);
    chk("locked cmd", acts, 16'h0);
    u_host.wr(8'h21, 16'h1011);
    chk("locked wave", waveform_run, 16'h0);
    u_host.wr(8'h20, 16'h3000);
    u_host.wr(8'h1f, 16'h0fff);
    chk("bad password", map_write_guard, 16'h1);
    u_host.wr(8'h20, 16'h0a00);
    chk("serial key", acts, 16'h0);
    u_host.unlock(16'h0fff);
    chk("unlocked", map_write_guard, 16'h0);
    u_host.wr(8'h1f, 16'h4fff);
    u_host.wr(8'h20, 16'h0a00, 1'b1);
    chk("two wire key", acts, 16'h80);
    repeat (2) @(negedge clk);
    chk("reset unlocks", map_write_guard, 16'h0);
    rc(8'h22, 16'h20ab);
    $display("test lock done");
    end_sim();
  end
endmodule : common_control_status_regs_tb_top
